// ===== verilog/eeprom_seq_pkg.sv
/*
  Constants, types and helper functions shared by the serial EEPROM
  command sequencer and its page-load FIFO.
  Assumes a 200 MHz core clock and a 17-bit byte-addressed array.
*/
package eeprom_seq_pkg;

  // ==========================================================
  // Command opcodes
  localparam logic [7:0] OP_READ    = 8'h03;
  localparam logic [7:0] OP_WRITE   = 8'h02;
  localparam logic [7:0] OP_STATUS  = 8'h05;
  localparam logic [7:0] SET_WRITE_LATCH_CMD   = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;

  // ==========================================================
  // Address and data layout
  localparam int ADDR_BITS  = 17;
  localparam int BYTE_BITS  = 8;
  localparam int PG_WIDTH   = ADDR_BITS + BYTE_BITS;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] ADDR_LAST_BIT = 5'h17;
  localparam logic [4:0] BYTE_LAST_BIT = 5'h07;
  localparam logic [16:0] QUARTER_BASE = 17'h18000;
  localparam logic [16:0] HALF_BASE    = 17'h10000;

  // ==========================================================
  // Status byte field positions
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH    = 1;
  localparam int ST_LEVEL_LO = 2;
  localparam int ST_LEVEL_HI = 3;
  localparam int ST_HW_PROT  = 7;

  // ==========================================================
  // Pin synchroniser lanes
  localparam int CS_IDX  = 0;
  localparam int SCK_IDX = 1;
  localparam int SI_IDX  = 2;

  // ==========================================================
  // Self-timed write cycle: time in microseconds, clock in MHz.
  localparam int TWC_US     = 5000;
  localparam int CLK_MHZ    = 200;
  localparam int TWC_CYCLES = TWC_US * CLK_MHZ;

  typedef enum logic [2:0] {
    PH_OPCODE, PH_ADDR, PH_RDATA, PH_WDATA,
    PH_STATUS, PH_SET_LATCH, PH_CLR_LATCH, PH_IGNORE
  } phase_type;

  // True when the byte lies inside the block-protected range.
  function automatic logic is_protected(input logic [1:0] level,
                                        input logic [16:0] addr);
    case (level)
      2'h1:    is_protected = (addr >= QUARTER_BASE);
      2'h2:    is_protected = (addr >= HALF_BASE);
      2'h3:    is_protected = 1'b1;
      default: is_protected = 1'b0;
    endcase
  endfunction

  // Next byte address inside the same row; upper bits stay put.
  function automatic logic [16:0] row_inc(input logic [16:0] addr);
    row_inc = {addr[16:8], 8'(addr[7:0] + 8'h01)};
  endfunction

endpackage

// ===== verilog/page_fifo.sv
/*
  Page-load FIFO between the sequencer and the array's page latch.
  Assumes one clock domain; both sides use valid/ready handshakes.
*/
`timescale 1ns/10ps
module page_fifo
  import eeprom_seq_pkg::*;
#(
  parameter int WIDTH = PG_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } fifo_state_type;

  fifo_state_type st_q;
  fifo_state_type st_d;

  // ==========================================================
  // Flags come straight from the pointers, so full is exact.
  assign in_ready  = (AW+1)'(st_q.wp - st_q.rp) != FULL_CNT;
  assign out_valid = st_q.wp != st_q.rp;
  assign out_data  = st_q.mem[st_q.rp[AW-1:0]];

  // Pointer and storage update.
  always_comb begin
    st_d = st_q;
    if (in_valid && in_ready) begin
      st_d.mem[st_q.wp[AW-1:0]] = in_data;
      st_d.wp = (AW+1)'(st_q.wp + 1'b1);
    end
    if (out_valid && out_ready) begin
      st_d.rp = (AW+1)'(st_q.rp + 1'b1);
    end
  end

  // Storage and pointers; reset leaves the queue empty.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// ===== verilog/eeprom_seq.sv
/*
  Command sequencer of a serial EEPROM slave on a mode 0/3 serial
  link: read, byte and page write, write latch, status polling.
  Assumes a synchronous array outside: read data valid one cycle
  after the read address, and a page latch fed by a FIFO that is
  programmed on a start pulse.
*/
`timescale 1ns/10ps

module eeprom_seq
  import eeprom_seq_pkg::*;
#(
  parameter int unsigned WC_CYCLES = TWC_CYCLES
) (
  input  wire logic          core_clk,
  input  wire logic          arst_n,
  input  wire logic          cs_n,
  input  wire logic          sck,
  input  wire logic          si,
  output logic               so,
  output logic               so_oe,
  input  wire logic          protect_level_hi,
  input  wire logic          protect_level_lo,
  input  wire logic          hw_protect_enable,
  output logic               write_enable_latch,
  output logic               busy_flag,
  output logic        [16:0] mem_rd_addr,
  input  wire logic   [7:0]  mem_rd_data,
  output logic               pg_valid,
  input  wire logic          pg_ready,
  output logic        [24:0] pg_data,
  output logic               prog_start
);

  localparam logic [19:0] WC_LAST = 20'(WC_CYCLES - 1);

  typedef struct packed {
    phase_type   phase;
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic [2:0]  prev;
    logic [4:0]  bit_cnt;
    logic [7:0]  sh_in;
    logic [7:0]  sh_out;
    logic [16:0] addr;
    logic        is_write;
    logic        got_byte;
    logic        oe;
    logic        wr_latch;
    logic        busy;
    logic        commit_wait;
    logic        start;
    logic [19:0] wc_cnt;
    logic        push_v;
    logic [24:0] push_data;
  } seq_state_type;

  seq_state_type st_q;
  seq_state_type st_d;

  logic        push_ready;
  logic        fifo_valid;
  logic        cs_low;
  logic        cs_rise;
  logic        sck_rise;
  logic        sck_fall;
  logic        in_bit;
  logic [1:0]  level;
  logic [7:0]  status_byte;
  logic [7:0]  next_byte;

  // ==========================================================
  // Pin edges, seen only after the two-stage synchroniser.
  assign cs_low   = !st_q.sync2[CS_IDX];
  assign cs_rise  = st_q.sync2[CS_IDX] && !st_q.prev[CS_IDX];
  assign sck_rise = st_q.sync2[SCK_IDX] && !st_q.prev[SCK_IDX];
  assign sck_fall = !st_q.sync2[SCK_IDX] && st_q.prev[SCK_IDX];
  assign in_bit   = st_q.sync2[SI_IDX];
  assign level    = {protect_level_hi, protect_level_lo};
  assign next_byte = {st_q.sh_in[6:0], in_bit};

  // Live status value, rebuilt for every byte of a poll.
  always_comb begin
    status_byte          = 8'h00;
    status_byte[ST_BUSY] = st_q.busy;
    status_byte[ST_LATCH]    = st_q.wr_latch;
    status_byte[ST_LEVEL_LO] = protect_level_lo;
    status_byte[ST_LEVEL_HI] = protect_level_hi;
    status_byte[ST_HW_PROT]  = hw_protect_enable;
  end

  // ==========================================================
  // Outputs, all taken from state flip-flops.
  assign so                 = st_q.sh_out[7];
  assign so_oe              = st_q.oe;
  assign write_enable_latch = st_q.wr_latch;
  assign busy_flag          = st_q.busy;
  assign mem_rd_addr        = st_q.addr;
  assign prog_start         = st_q.start;

  // ==========================================================
  // Sequencer next state.
  always_comb begin
    st_d       = st_q;
    st_d.sync1 = {si, sck, cs_n};
    st_d.sync2 = st_q.sync1;
    st_d.prev  = st_q.sync2;
    st_d.start = 1'b0;
    if (st_q.push_v && push_ready) begin
      st_d.push_v = 1'b0;
    end

    if (cs_rise) begin
      // Deselect closes a command; only whole sequences act.
      case (st_q.phase)
        PH_SET_LATCH: st_d.wr_latch = 1'b1;
        PH_CLR_LATCH: st_d.wr_latch = 1'b0;
        PH_WDATA: begin
          // Only a deselect on a byte boundary counts.
          if (st_q.got_byte && st_q.bit_cnt == 5'h00 &&
              st_q.wr_latch) begin
            st_d.busy        = 1'b1;
            st_d.commit_wait = 1'b1;
          end
        end
        default: ;
      endcase
    end

    if (!cs_low) begin
      st_d.phase    = PH_OPCODE;
      st_d.bit_cnt  = 5'h00;
      st_d.got_byte = 1'b0;
      st_d.oe       = 1'b0;
    end else if (sck_rise) begin
      case (st_q.phase)
        PH_OPCODE: begin
          st_d.sh_in   = next_byte;
          st_d.bit_cnt = 5'(st_q.bit_cnt + 5'h01);
          if (st_q.bit_cnt == BYTE_LAST_BIT) begin
            st_d.bit_cnt = 5'h00;
            if (st_q.busy && next_byte != OP_STATUS) begin
              st_d.phase = PH_IGNORE;
            end else if (next_byte == OP_READ) begin
              st_d.phase    = PH_ADDR;
              st_d.is_write = 1'b0;
            end else if (next_byte == OP_WRITE) begin
              st_d.is_write = 1'b1;
              st_d.phase    = st_q.wr_latch ? PH_ADDR : PH_IGNORE;
            end else if (next_byte == OP_STATUS) begin
              st_d.phase = PH_STATUS;
            end else if (next_byte == SET_WRITE_LATCH_CMD) begin
              st_d.phase = PH_SET_LATCH;
            end else if (next_byte == CLEAR_WRITE_LATCH_CMD) begin
              st_d.phase = PH_CLR_LATCH;
            end else begin
              st_d.phase = PH_IGNORE;
            end
          end
        end
        PH_ADDR: begin
          // Upper seven bits fall off the top of the register.
          st_d.addr    = {st_q.addr[15:0], in_bit};
          st_d.bit_cnt = 5'(st_q.bit_cnt + 5'h01);
          if (st_q.bit_cnt == ADDR_LAST_BIT) begin
            st_d.bit_cnt = 5'h00;
            st_d.phase   = st_q.is_write ? PH_WDATA : PH_RDATA;
          end
        end
        PH_WDATA: begin
          st_d.sh_in   = next_byte;
          st_d.bit_cnt = 5'(st_q.bit_cnt + 5'h01);
          if (st_q.bit_cnt == BYTE_LAST_BIT) begin
            st_d.bit_cnt  = 5'h00;
            st_d.got_byte = 1'b1;
            st_d.addr     = row_inc(st_q.addr);
            // A stuck FIFO loses the older byte; it drains far
            // faster than the link can deliver.
            if (!is_protected(level, st_q.addr)) begin
              st_d.push_v    = 1'b1;
              st_d.push_data = {st_q.addr, next_byte};
            end
          end
        end
        PH_RDATA, PH_STATUS: begin
          // Input is ignored; the count only paces the loads.
          st_d.bit_cnt = (st_q.bit_cnt == BYTE_LAST_BIT) ?
                         5'h00 : 5'(st_q.bit_cnt + 5'h01);
        end
        default: ;
      endcase
    end else if (sck_fall) begin
      if (st_q.phase == PH_RDATA || st_q.phase == PH_STATUS) begin
        st_d.oe = 1'b1;
        if (st_q.bit_cnt == 5'h00) begin
          if (st_q.phase == PH_RDATA) begin
            st_d.sh_out = mem_rd_data;
            st_d.addr   = 17'(st_q.addr + 17'h00001);
          end else begin
            st_d.sh_out = status_byte;
          end
        end else begin
          st_d.sh_out = {st_q.sh_out[6:0], 1'b0};
        end
      end
    end

    // Programming starts once every loaded byte reached the latch.
    if (st_q.commit_wait) begin
      if (!st_q.push_v && !fifo_valid) begin
        st_d.commit_wait = 1'b0;
        st_d.start       = 1'b1;
        st_d.wc_cnt      = 20'h00000;
      end
    end else if (st_q.busy) begin
      if (st_q.wc_cnt == WC_LAST) begin
        st_d.busy     = 1'b0;
        st_d.wr_latch = 1'b0;
      end else begin
        st_d.wc_cnt = 20'(st_q.wc_cnt + 20'h00001);
      end
    end
  end

  // ==========================================================
  // State register; only the CS lane resets high so the select looks inactive.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q       <= '0;
      st_q.sync1 <= 3'h1;
      st_q.sync2 <= 3'h1;
      st_q.prev  <= 3'h1;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Page-load buffer toward the array latch.
  page_fifo #(
    .WIDTH (PG_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (st_q.push_v),
    .in_ready  (push_ready),
    .in_data   (st_q.push_data),
    .out_valid (fifo_valid),
    .out_ready (pg_ready),
    .out_data  (pg_data)
  );
  assign pg_valid = fifo_valid;

  // ==========================================================
  // Checks on the sequencer.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence desel_s;
    cs_rise;
  endsequence

  sequence start_s;
    st_q.commit_wait ##[1:1000] st_q.start;
  endsequence

  busy_from_desel_a: assert property (
    $rose(st_q.busy) |-> $past(cs_rise) && $past(st_q.wr_latch))
    else $error("busy set without a valid deselect");

  latch_clear_end_a: assert property (
    $fell(st_q.busy) |-> !st_q.wr_latch)
    else $error("write latch still set after write cycle");

  write_needs_latch_a: assert property (
    st_q.phase == PH_WDATA |-> st_q.wr_latch)
    else $error("write data accepted without write latch");

  protect_skip_a: assert property (
    $rose(st_q.push_v) |->
      !is_protected(level, st_q.push_data[24:8]))
    else $error("protected byte sent to page latch");

  row_hold_a: assert property (
    (st_q.phase == PH_WDATA && $past(st_q.phase) == PH_WDATA)
      |-> st_q.addr[16:8] == $past(st_q.addr[16:8]))
    else $error("page write changed the row");

  read_inc_a: assert property (
    (st_q.phase == PH_RDATA && $past(st_q.phase) == PH_RDATA &&
     st_q.addr != $past(st_q.addr))
      |-> st_q.addr == 17'($past(st_q.addr) + 17'h00001))
    else $error("read address did not step by one");

  busy_ignore_a: assert property (
    st_q.busy |-> st_q.phase != PH_ADDR)
    else $error("command accepted while busy");

  status_load_a: assert property (
    (st_q.phase == PH_STATUS && sck_fall && st_q.bit_cnt == 5'h00)
      |=> st_q.sh_out[ST_BUSY] == $past(st_q.busy) && st_q.oe)
    else $error("status byte does not show busy");

  wc_hold_a: assert property (
    desel_s ##1 start_s |=> st_q.busy[*2])
    else $error("write cycle ended too early");

  set_latch_a: assert property (
    (cs_rise && st_q.phase == PH_SET_LATCH) |=> st_q.wr_latch)
    else $error("write latch not set at deselect");

  start_drained_a: assert property (
    st_q.start |-> st_q.busy && !fifo_valid && !st_q.push_v)
    else $error("programming started before page drained");

  ignore_quiet_a: assert property (
    st_q.phase == PH_IGNORE |-> !st_q.oe)
    else $error("ignored command drove the output");

  read_load_a: assert property (
    (cs_low && st_q.phase == PH_RDATA && sck_fall && st_q.bit_cnt == 5'h00)
      |=> st_q.sh_out == $past(mem_rd_data) && st_q.oe)
    else $error("read byte not loaded for shifting");

endmodule

// ===== tb/spi_host_model.sv
/*
  Behavioural serial link master for the EEPROM sequencer bench.
  Assumes the caller runs it from one process; signals move on the
  falling edge of core_clk, sck period is 16 core cycles (80 ns).
*/
`timescale 1ns/10ps
module spi_host_model (
  input  wire logic core_clk,
  input  wire logic so,
  input  wire logic so_oe,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  logic oe_seen;

  // ==========================================================
  // Idle state
  // The clock stays low between frames, as mode 0 keeps it.
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    oe_seen = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // ==========================================================
  // One byte, MSB first, data set while the clock is low.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      wait_clk(8);
      sck = 1'b1;
      rx[i] = so_oe ? so : ~so; // A released line reads as garbage.
      oe_seen = oe_seen | so_oe;
      wait_clk(8);
      sck = 1'b0;
    end
  endtask

  // ==========================================================
  // Whole frame: opcode, optional address, bytes out, bytes in.
  // Pages stay within one row unless a caller means to wrap.
  task automatic frame(input logic [7:0] op, input logic [23:0] addr,
                       input logic use_addr, input logic [7:0] wq[$],
                       input int n_rd, output logic [7:0] rq[$]);
    logic [7:0] b;
    cs_n = 1'b0;
    oe_seen = 1'b0;
    rq.delete();
    wait_clk(8);
    xfer(op, b);
    if (use_addr) begin
      for (int k = 2; k >= 0; k--) xfer(addr[k*8 +: 8], b);
    end
    foreach (wq[k]) xfer(wq[k], b);
    repeat (n_rd) begin
      xfer(~b, b);
      rq.push_back(b);
    end
    // Deselect in the low phase right after the last bit.
    wait_clk(4);
    cs_n = 1'b1;
    si = ~si;
    wait_clk(16);
  endtask
endmodule

// ===== tb/spi_eeprom_read_write_sequencer_tb.sv
/*
  Self-checking bench of the EEPROM command sequencer.
  Assumes the link master model and a simple array model: read data
  one cycle after the address, page words taken when not stalled.
*/
`timescale 1ns/10ps
module spi_eeprom_read_write_sequencer_tb;
  import eeprom_seq_pkg::*;
  localparam int WC = 2000;
  logic        core_clk, arst_n, cs_n, sck, si, so, so_oe;
  logic        lvl_hi, lvl_lo, hwpe, wr_latch, busy, busy_d;
  logic        pg_valid, pg_ready, prog_start, stall;
  logic [16:0] mem_rd_addr;
  logic [7:0]  mem_rd_data;
  logic [24:0] pg_data;
  logic [24:0] pushed[$];
  logic [7:0]  none[$];
  int          error_cnt = 0, samples_checked = 0, starts = 0;
  int          pcnt = 0, dur = 0;

  // ==========================================================
  // Clock, design and partner
  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  eeprom_seq #(.WC_CYCLES(WC)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck),
    .si(si), .so(so), .so_oe(so_oe), .protect_level_hi(lvl_hi),
    .protect_level_lo(lvl_lo), .hw_protect_enable(hwpe),
    .write_enable_latch(wr_latch), .busy_flag(busy),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .pg_valid(pg_valid), .pg_ready(pg_ready), .pg_data(pg_data),
    .prog_start(prog_start));

  spi_host_model host (.core_clk(core_clk), .so(so), .so_oe(so_oe),
                       .cs_n(cs_n), .sck(sck), .si(si));

  // ==========================================================
  // Array model; contents mix all address bits so wraps show.
  function automatic logic [7:0] fmem(input logic [16:0] a);
    return a[7:0] + a[15:8] + {7'h00, a[16]} + 8'h5A;
  endfunction

  always @(negedge core_clk) begin
    mem_rd_data <= fmem(mem_rd_addr);
    pg_ready <= ~stall;
  end

  // Words taken by the page latch, start pulses and write time.
  always @(posedge core_clk) begin
    if (pg_valid === 1'b1 && pg_ready === 1'b1) pushed.push_back(pg_data);
    if (prog_start === 1'b1) starts++;
    pcnt <= (prog_start === 1'b1) ? 1 : pcnt + 1;
    if (busy_d === 1'b1 && busy === 1'b0) dur <= pcnt;
    busy_d <= busy;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op);
    logic [7:0] q[$];
    host.frame(op, 24'h000000, 1'b0, none, 0, q);
  endtask

  task automatic rd_status(output logic [7:0] st);
    logic [7:0] q[$];
    host.frame(OP_STATUS, 24'h000000, 1'b0, none, 1, q);
    st = q[0];
  endtask

  // Bounded wait for the write cycle to end.
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (8) @(negedge core_clk);
    while (busy !== 1'b0 && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 20000) begin
      error_cnt++;
      end_of_test();
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_basic();
    logic [7:0] st;
    logic [7:0] w[$];
    logic [7:0] q[$];
    check(32'({so_oe, wr_latch, busy}), 32'(0), "rst");
    check(32'({pg_valid, prog_start}), 32'(0), "rst out");
    {lvl_hi, hwpe} = 2'h3;
    rd_status(st);
    check(32'(st), 32'(8'h88), "status");
    {lvl_hi, hwpe} = 2'h0;
    w = '{8'h55};
    host.frame(OP_WRITE, 24'h000010, 1'b1, w, 0, q);
    check(32'(pushed.size()) + 32'(starts), 32'(0), "no latch");
    check(32'(busy), 32'(0), "no busy");
    cmd(SET_WRITE_LATCH_CMD);
    check(32'(wr_latch), 32'(1), "set latch");
    cmd(CLEAR_WRITE_LATCH_CMD);
    check(32'(wr_latch), 32'(0), "clear latch");
  endtask

  task automatic t_page();
    logic [7:0]  st;
    logic [7:0]  w[$];
    logic [7:0]  q[$];
    logic [24:0] ew[3];
    int          n;
    int          s0;
    logic [24:0] pw;
    ew = '{{17'h001FE, 8'hA1}, {17'h001FF, 8'hB2}, {17'h00100, 8'hC3}};
    cmd(SET_WRITE_LATCH_CMD);
    pushed.delete();
    s0 = starts;
    stall = 1'b1;
    // The last byte runs past the row end on purpose, to see the wrap.
    w = '{8'hA1, 8'hB2, 8'hC3};
    host.frame(OP_WRITE, 24'hFE01FE, 1'b1, w, 0, q);
    check(32'(busy), 32'(1), "busy at deselect");
    check(32'(starts - s0), 32'(0), "start before drain");
    stall = 1'b0;
    rd_status(st);
    check(32'(st[1:0]), 32'(3), "busy status");
    host.frame(OP_READ, 24'h000000, 1'b1, none, 2, q);
    check(32'(host.oe_seen), 32'(0), "read while busy");
    // Polling keeps each check short of the long write time.
    n = 0;
    while (st[0] === 1'b1 && n < 20) begin
      rd_status(st);
      n++;
    end
    check(32'(st[1:0]), 32'(0), "ready status");
    check(32'(dur >= WC - 2 && dur <= WC + 2), 32'(1), "write time");
    check(32'(pushed.size()), 32'(3), "page count");
    foreach (ew[i]) begin
      pw = (i < pushed.size()) ? pushed[i] : 25'h1FFFFFF;
      check(32'(pw), 32'(ew[i]), "page word");
    end
    check(32'(starts - s0), 32'(1), "one cycle");
  endtask

  task automatic t_prot();
    logic [16:0] a[3];
    logic [7:0]  w[$];
    logic [7:0]  q[$];
    logic        prot;
    a = '{17'h00000, 17'h10000, 17'h18000};
    for (int l = 0; l < 4; l++) begin
      foreach (a[j]) begin
        {lvl_hi, lvl_lo} = 2'(l);
        pushed.delete();
        cmd(SET_WRITE_LATCH_CMD);
        w = '{8'(l * 16 + j)};
        host.frame(OP_WRITE, {7'h00, a[j]}, 1'b1, w, 0, q);
        wait_idle();
        prot = (l == 3) || (l == 2 && a[j] >= 17'h10000) ||
               (l == 1 && a[j] >= 17'h18000);
        check(32'(pushed.size()), prot ? 32'(0) : 32'(1), "protect");
      end
    end
    {lvl_hi, lvl_lo} = 2'h0;
  endtask

  task automatic t_read();
    logic [7:0] q[$];
    host.frame(OP_READ, 24'hFFFFFF, 1'b1, none, 2, q);
    check(32'(q[0]), 32'(fmem(17'h1FFFF)), "read top");
    check(32'(q[1]), 32'(fmem(17'h00000)), "read wrap");
    host.frame(OP_READ, 24'h5A01FF, 1'b1, none, 2, q);
    check(32'(q[0]), 32'(fmem(17'h001FF)), "read row end");
    check(32'(q[1]), 32'(fmem(17'h00200)), "read next row");
    check(32'(so_oe), 32'(0), "so released");
  endtask

  // ==========================================================
  // Main sequence and hang guard
  initial begin
    arst_n = 1'b0;
    {lvl_hi, lvl_lo, hwpe, stall} = 4'h0;
    repeat (20) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    t_basic();
    t_page();
    t_prot();
    t_read();
    end_of_test();
  end

  initial begin
    #480000;
    error_cnt++;
    end_of_test();
  end
endmodule
